// >>> verilog/synth_serial_cfg.svh
// Purpose: field positions and timing figures of the serial latch block
// Assumes: 24-bit programming word, control bits in the two lsbs
// Notes:   definitions only
`ifndef SYNTH_SERIAL_CFG_SVH
`define SYNTH_SERIAL_CFG_SVH
`define WORD_W      24
`define SEL_MSB     1
`define SEL_LSB     0
`define REF_MSB     15
`define REF_LSB     2
`define ABP_MSB     17
`define ABP_LSB     16
`define MAIN_MSB    20
`define MAIN_LSB    8
`define SWAL_MSB    7
`define SWAL_LSB    2
`define GAIN_BIT    21
`define HOLD_BIT    2
`define PD1_BIT     3
`define MUX_MSB     6
`define MUX_LSB     4
`define FLEN_BIT    9
`define FLMODE_BIT  10
`define TC_MSB      14
`define TC_LSB      11
`define CUR1_MSB    17
`define CUR1_LSB    15
`define CUR2_MSB    20
`define CUR2_LSB    18
`define PD2_BIT     21
`define PRE_MSB     23
`define PRE_LSB     22
`define WORD_RESET  24'h000000
`define CLK_NS      50
`define LOCK_IN_NS  15
`define LOCK_OUT_NS 25
`define LOCK_COUNT  3
`endif

// >>> verilog/synth_serial_pkg.sv
// Purpose: types shared by the serial latch block
// Assumes: nothing
// Notes:   encodings written out
package synth_serial_pkg;
    typedef enum logic [1:0] {
        SEL_REF  = 2'b00,
        SEL_FB   = 2'b01,
        SEL_FUNC = 2'b10,
        SEL_INIT = 2'b11
    } latch_sel_t;
    typedef enum logic [1:0] {
        PWR_ON   = 2'b00,
        PWR_WAIT = 2'b01,
        PWR_DOWN = 2'b10
    } pwr_state_t;
endpackage : synth_serial_pkg

// >>> verilog/synth_serial_latch_control.sv
// Purpose: three-wire programming port, latches, dividers, power-down,
//          lock detect and fast-lock current control of a pll synthesizer
// Assumes: serial pins and chip enable are asynchronous; tick, event and
//          phase-error inputs come from logic on ref_clk_i
// Notes:   phase error is given in ref_clk_i cycles
`timescale 1ns/1ps
`include "synth_serial_cfg.svh"
module synth_serial_latch_control
    import synth_serial_pkg::*;
#(
    parameter int         ERR_W     = 8,
    parameter int         LOCK_IN   = 1,  // below this error counts as small
    parameter int         LOCK_OUT  = 1,  // above this error counts as large
    parameter logic [7:0] TMO_BASE  = 8'h03,
    parameter logic [7:0] TMO_STEP  = 8'h04,
    parameter logic [2:0] MUX_LOW   = 3'h0,
    parameter logic [2:0] MUX_DLD   = 3'h1,
    parameter logic [2:0] MUX_FB    = 3'h2,
    parameter logic [2:0] MUX_HIGH  = 3'h3,
    parameter logic [2:0] MUX_REF   = 3'h4,
    parameter logic [2:0] MUX_ALD   = 3'h5,
    parameter logic [2:0] MUX_SDATA = 3'h6
) (
    input  wire logic             ref_clk_i,               // block clock
    input  wire logic             rst_i,                   // async reset, high
    input  wire logic             serial_clk_i,            // serial clock pin
    input  wire logic             serial_data_i,           // serial data pin
    input  wire logic             load_strobe_i,           // latch load pin
    input  wire logic             chip_enable_i,           // chip enable pin
    input  wire logic             ref_tick_i,              // reference input cycle
    input  wire logic             fb_tick_i,               // prescaler output cycle
    input  wire logic             pd_event_i,              // charge-pump event
    input  wire logic [ERR_W-1:0] phase_err_i,             // error with pd_event_i
    input  wire logic             pd_active_i,             // pfd output active
    output logic                  ref_pfd_o,               // reference divider out
    output logic                  fb_pfd_o,                // feedback divider out
    output logic                  modulus_o,               // prescaler p+1 select
    output logic                  powered_down_o,          // device powered down
    output logic                  cp_tristate_o,           // charge pump floated
    output logic [2:0]            cp_current_o,            // current setting
    output logic                  digital_lock_o,          // digital lock detect
    output logic                  multiplexed_output_o,    // mux pin level
    output logic                  multiplexed_output_oe_o, // mux pin drive
    output logic [1:0]            prescale_sel_o,          // prescaler value
    output logic [1:0]            backlash_width_o         // anti-backlash width
);

    localparam int LOCK_IN_CYC  = (`LOCK_IN_NS / `CLK_NS) < 1 ? 1 :
                                  (`LOCK_IN_NS / `CLK_NS);
    localparam int LOCK_OUT_CYC = ((`LOCK_OUT_NS + `CLK_NS - 1) / `CLK_NS) < 1 ? 1 :
                                  ((`LOCK_OUT_NS + `CLK_NS - 1) / `CLK_NS);
    localparam logic [ERR_W-1:0] ERR_SMALL = ERR_W'(LOCK_IN * LOCK_IN_CYC);
    localparam logic [ERR_W-1:0] ERR_LARGE = ERR_W'(LOCK_OUT * LOCK_OUT_CYC);
    localparam logic [1:0]       LOCK_LAST = 2'(`LOCK_COUNT - 1);

    // pin synchronisers: sclk, data, strobe, enable
    logic [3:0]              sync1_q;
    logic [3:0]              sync2_q;
    logic [3:0]              sync3_q;
    logic [`WORD_W-1:0]      shift_q;
    logic [`WORD_W-1:0]      ref_word_q;
    logic [`WORD_W-1:0]      fb_word_q;
    logic [`WORD_W-1:0]      func_word_q;
    logic                    gain_q;
    logic                    first_fb_q;
    logic                    init_pulse_q;
    pwr_state_t              pwr_q;
    logic [13:0]             r_cnt_q;
    logic [12:0]             b_cnt_q;
    logic [5:0]              a_cnt_q;
    logic [7:0]              tmo_cnt_q;
    logic [1:0]              good_cnt_q;
    logic                    lock_q;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            sync3_q <= 4'h0;
        end else begin
            sync1_q <= {chip_enable_i, load_strobe_i, serial_data_i, serial_clk_i};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    wire logic       sclk_rise = sync2_q[0] & ~sync3_q[0];
    wire logic       sdata     = sync2_q[1];
    wire logic       le_rise   = sync2_q[2] & ~sync3_q[2];
    wire logic       ce        = sync2_q[3];
    wire latch_sel_t sel       = latch_sel_t'(shift_q[`SEL_MSB:`SEL_LSB]);

    wire logic       hold_bit  = func_word_q[`HOLD_BIT];
    wire logic       pd1       = func_word_q[`PD1_BIT];
    wire logic       pd2       = func_word_q[`PD2_BIT];
    wire logic       fl_en     = func_word_q[`FLEN_BIT];
    wire logic       fl_mode2  = func_word_q[`FLMODE_BIT];
    wire logic       pwr_down  = (pwr_q == PWR_DOWN);
    wire logic       cnt_hold  = hold_bit | pwr_down | init_pulse_q;

    // shifting never looks at power state so the host can program while down
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_q <= `WORD_RESET;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[`WORD_W-2:0], sdata};
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_word_q  <= `WORD_RESET;
            fb_word_q   <= `WORD_RESET;
            func_word_q <= `WORD_RESET;
        end else if (le_rise) begin
            if (sel == SEL_REF) begin
                ref_word_q <= shift_q;
            end else if (sel == SEL_FB) begin
                fb_word_q <= shift_q;
            end else begin
                func_word_q <= shift_q;
            end
        end
    end

    // init load pulses the counters; so does the first feedback load after it
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_fb_q   <= 1'b0;
            init_pulse_q <= 1'b0;
        end else begin
            init_pulse_q <= le_rise & ((sel == SEL_INIT) |
                            ((sel == SEL_FB) & first_fb_q));
            if (le_rise && sel == SEL_INIT) begin
                first_fb_q <= 1'b1;
            end else if (le_rise && sel == SEL_FB) begin
                first_fb_q <= 1'b0;
            end
        end
    end

    wire logic [7:0] tmo_limit = 8'(TMO_BASE + TMO_STEP * func_word_q[`TC_MSB:`TC_LSB]);
    wire logic       tmo_run   = fl_en & fl_mode2 & gain_q & ~pwr_down;
    wire logic       tmo_done  = tmo_run & pd_event_i & (tmo_cnt_q >= tmo_limit - 8'h01);

    // a host write of the gain bit wins over a timeout in the same cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            gain_q <= 1'b0;
        end else if (le_rise && sel == SEL_FB) begin
            gain_q <= shift_q[`GAIN_BIT];
        end else if (tmo_done) begin
            gain_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmo_cnt_q <= 8'h00;
        end else if (!tmo_run || tmo_done || (le_rise && sel == SEL_FB)) begin
            tmo_cnt_q <= 8'h00;
        end else if (pd_event_i) begin
            tmo_cnt_q <= tmo_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pwr_q <= PWR_DOWN;
        end else begin
            case (pwr_q)
                PWR_ON: begin
                    if (!ce || (pd1 && !pd2)) begin
                        pwr_q <= PWR_DOWN;
                    end else if (pd1 && pd2) begin
                        pwr_q <= PWR_WAIT;
                    end
                end
                PWR_WAIT: begin
                    if (!ce) begin
                        pwr_q <= PWR_DOWN;
                    end else if (!pd1) begin
                        pwr_q <= PWR_ON;
                    end else if (!pd2 || pd_event_i) begin
                        pwr_q <= PWR_DOWN;
                    end
                end
                PWR_DOWN: begin
                    if (ce && !pd1) begin
                        pwr_q <= PWR_ON;
                    end
                end
                default: begin
                    pwr_q <= PWR_DOWN;
                end
            endcase
        end
    end

    // both dividers leave hold on the same cycle, which keeps them aligned
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            r_cnt_q   <= 14'h0000;
            ref_pfd_o <= 1'b0;
        end else if (cnt_hold) begin
            r_cnt_q   <= ref_word_q[`REF_MSB:`REF_LSB];
            ref_pfd_o <= 1'b0;
        end else if (ref_tick_i) begin
            ref_pfd_o <= (r_cnt_q <= 14'h0001);
            if (r_cnt_q <= 14'h0001) begin
                r_cnt_q <= ref_word_q[`REF_MSB:`REF_LSB];
            end else begin
                r_cnt_q <= r_cnt_q - 14'h0001;
            end
        end else begin
            ref_pfd_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            b_cnt_q  <= 13'h0000;
            a_cnt_q  <= 6'h00;
            fb_pfd_o <= 1'b0;
        end else if (cnt_hold) begin
            b_cnt_q  <= fb_word_q[`MAIN_MSB:`MAIN_LSB];
            a_cnt_q  <= fb_word_q[`SWAL_MSB:`SWAL_LSB];
            fb_pfd_o <= 1'b0;
        end else if (fb_tick_i) begin
            fb_pfd_o <= (b_cnt_q <= 13'h0001);
            if (b_cnt_q <= 13'h0001) begin
                b_cnt_q <= fb_word_q[`MAIN_MSB:`MAIN_LSB];
                a_cnt_q <= fb_word_q[`SWAL_MSB:`SWAL_LSB];
            end else begin
                b_cnt_q <= b_cnt_q - 13'h0001;
                if (a_cnt_q != 6'h00) begin
                    a_cnt_q <= a_cnt_q - 6'h01;
                end
            end
        end else begin
            fb_pfd_o <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            good_cnt_q <= 2'h0;
            lock_q     <= 1'b0;
        end else if (pwr_down) begin
            good_cnt_q <= 2'h0;
            lock_q     <= 1'b0;
        end else if (pd_event_i) begin
            if (phase_err_i < ERR_SMALL) begin
                if (good_cnt_q == LOCK_LAST) begin
                    lock_q <= 1'b1;
                end
                if (good_cnt_q < LOCK_LAST) begin
                    good_cnt_q <= good_cnt_q + 2'h1;
                end
            end else begin
                good_cnt_q <= 2'h0;
                if (phase_err_i > ERR_LARGE) begin
                    lock_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            multiplexed_output_o    <= 1'b0;
            multiplexed_output_oe_o <= 1'b1;
        end else begin
            multiplexed_output_oe_o <= 1'b1;
            case (func_word_q[`MUX_MSB:`MUX_LSB])
                MUX_LOW:   multiplexed_output_o <= 1'b0;
                MUX_DLD:   multiplexed_output_o <= lock_q;
                MUX_FB:    multiplexed_output_o <= fb_pfd_o;
                MUX_HIGH:  multiplexed_output_o <= 1'b1;
                MUX_REF:   multiplexed_output_o <= ref_pfd_o;
                MUX_SDATA: multiplexed_output_o <= shift_q[`WORD_W-1];
                MUX_ALD: begin
                    // open drain: pulled up, pulled low while the pfd fires
                    multiplexed_output_o    <= 1'b0;
                    multiplexed_output_oe_o <= pd_active_i;
                end
                default:   multiplexed_output_o <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cp_current_o <= 3'h0;
        end else if (fl_en && gain_q) begin
            cp_current_o <= func_word_q[`CUR2_MSB:`CUR2_LSB];
        end else begin
            cp_current_o <= func_word_q[`CUR1_MSB:`CUR1_LSB];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            modulus_o        <= 1'b0;
            powered_down_o   <= 1'b1;
            cp_tristate_o    <= 1'b1;
            digital_lock_o   <= 1'b0;
            prescale_sel_o   <= 2'h0;
            backlash_width_o <= 2'h0;
        end else begin
            modulus_o        <= (a_cnt_q != 6'h00) & ~cnt_hold;
            powered_down_o   <= pwr_down;
            cp_tristate_o    <= cnt_hold;
            digital_lock_o   <= lock_q;
            prescale_sel_o   <= func_word_q[`PRE_MSB:`PRE_LSB];
            backlash_width_o <= ref_word_q[`ABP_MSB:`ABP_LSB];
        end
    end

endmodule : synth_serial_latch_control

// >>> verif/host_serial_model.sv
// Purpose: host side of the three-wire programming port
// Assumes: clk_i is the block clock, used only to pace the pins
// Notes:   serial clock idles low between words; eight clocks a bit
`timescale 1ns/1ps
module host_serial_model (
    input  wire logic clk_i,         // pacing clock
    output logic      serial_clk_o,  // serial clock pin
    output logic      serial_data_o, // serial data pin
    output logic      load_strobe_o  // load pin
);
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        load_strobe_o = 1'b0;
    end
    task automatic send_word(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data_o <= w[i];
            serial_clk_o <= 1'b0;
            repeat (4) @(posedge clk_i);
            serial_clk_o <= 1'b1;
            repeat (4) @(posedge clk_i);
        end
        serial_clk_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        // hold time is over, so the line must not keep showing the last bit
        serial_data_o <= ~w[0];
        load_strobe_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        load_strobe_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : send_word
endmodule : host_serial_model

// >>> verif/synth_serial_latch_control_assertions.sv
// Purpose: concurrent checks on the serial latch block's ports
// Assumes: phase-detector events come several cycles apart
// Notes:   good-event count is not cleared by power-down, so it stays lenient
`timescale 1ns/1ps
module latch_control_checker #(
    parameter int ERR_W    = 8,
    parameter int LOCK_IN  = 1,
    parameter int LOCK_OUT = 1
) (
    input wire logic             ref_clk_i,      // clock
    input wire logic             rst_i,          // reset
    input wire logic             chip_enable_i,  // chip enable
    input wire logic             ref_tick_i,     // ref cycle
    input wire logic             fb_tick_i,      // fb cycle
    input wire logic             pd_event_i,     // pump event
    input wire logic [ERR_W-1:0] phase_err_i,    // phase error
    input wire logic             ref_pfd_o,      // ref pulse
    input wire logic             fb_pfd_o,       // fb pulse
    input wire logic             powered_down_o, // down
    input wire logic             cp_tristate_o,  // pump floated
    input wire logic             digital_lock_o  // lock
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [1:0] good_q;
    logic [1:0] good_d;
    logic       bad_evt;
    assign bad_evt = pd_event_i && (phase_err_i > ERR_W'(LOCK_OUT));
    always_comb begin
        good_d = good_q;
        if (pd_event_i && (phase_err_i >= ERR_W'(LOCK_IN)))
            good_d = 2'h0;
        else if (pd_event_i && (good_q != 2'h3))
            good_d = good_q + 2'h1;
    end
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i)
            good_q <= 2'h0;
        else
            good_q <= good_d;
    end
    a_ce_low_down: assert property (!chip_enable_i [*4] |=> powered_down_o)
        else $error("no power-down with chip enable low");
    a_down_tristate: assert property (powered_down_o && $past(powered_down_o) |-> cp_tristate_o)
        else $error("charge pump driven while down");
    a_down_lock_clear: assert property (powered_down_o [*3] |-> !digital_lock_o)
        else $error("lock held while down");
    a_down_no_pulse: assert property (powered_down_o [*3] |-> !ref_pfd_o && !fb_pfd_o)
        else $error("divider pulse while down");
    a_lock_three_good: assert property ($rose(digital_lock_o) |-> good_q == 2'h3)
        else $error("lock set before three good events");
    a_lock_drop_err: assert property (bad_evt |-> ##[1:2] !digital_lock_o)
        else $error("lock kept after large error");
    a_lock_keep: assert property ($fell(digital_lock_o) |-> powered_down_o ||
        $past(powered_down_o) || $past(powered_down_o, 2) || $past(bad_evt) || $past(bad_evt, 2))
        else $error("lock dropped without cause");
    a_ref_pulse_cause: assert property (ref_pfd_o |-> $past(ref_tick_i))
        else $error("ref pulse without tick");
    a_fb_pulse_cause: assert property (fb_pfd_o |-> $past(fb_tick_i))
        else $error("fb pulse without tick");
endmodule : latch_control_checker

// >>> verif/tb_top.sv
// Purpose: self-checking bench for the serial latch block
// Assumes: host model paces all serial traffic from ref_clk_i
// Notes:   reference and main counts of 3 keep divider checks short
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
        fail_count++; \
        $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); \
    end \
end
module tb_top;
    localparam logic [2:0] M_DLD  = 3'h1;
    localparam logic [2:0] M_HIGH = 3'h3;
    localparam logic [2:0] M_ALD  = 3'h5;
    localparam logic [2:0] M_SDATA = 3'h6;
    localparam logic [2:0] M_LOW  = 3'h0;
    localparam logic [7:0] TMO    = 8'h03;
    logic       ref_clk_i = 1'b0, rst_i = 1'b1, chip_enable_i = 1'b1, pd_active_i = 1'b0;
    logic       ref_tick_i = 1'b0, fb_tick_i = 1'b0, pd_event_i = 1'b0;
    logic [7:0] phase_err_i = 8'h00;
    logic       serial_clk_i, serial_data_i, load_strobe_i, ref_pfd_o, fb_pfd_o, modulus_o;
    logic       powered_down_o, cp_tristate_o, digital_lock_o;
    logic       multiplexed_output_o, multiplexed_output_oe_o;
    logic [2:0] cp_current_o;
    logic [1:0] prescale_sel_o, backlash_width_o;
    int         fail_count = 0, n_tests = 0, rp = 0, fp = 0, tp = 0, b_r, b_f;
    always #25 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        rp <= rp + int'(ref_pfd_o);
        fp <= fp + int'(fb_pfd_o);
        tp <= tp + int'(cp_tristate_o);
    end
    synth_serial_latch_control #(.MUX_DLD(M_DLD), .MUX_HIGH(M_HIGH), .MUX_ALD(M_ALD),
        .TMO_BASE(TMO)) synth_serial_latch_control_i (
        .ref_clk_i, .rst_i, .serial_clk_i, .serial_data_i, .load_strobe_i, .chip_enable_i,
        .ref_tick_i, .fb_tick_i, .pd_event_i, .phase_err_i, .pd_active_i, .ref_pfd_o,
        .fb_pfd_o, .modulus_o, .powered_down_o, .cp_tristate_o, .cp_current_o,
        .digital_lock_o, .multiplexed_output_o, .multiplexed_output_oe_o,
        .prescale_sel_o, .backlash_width_o);
    host_serial_model host_serial_model_i (.clk_i(ref_clk_i), .serial_clk_o(serial_clk_i),
        .serial_data_o(serial_data_i), .load_strobe_o(load_strobe_i));
    task automatic complete_run();
        if (fail_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : wt
    task automatic wr(input logic [23:0] w);
        host_serial_model_i.send_word(w);
    endtask : wr
    // k picks {ref tick, fb tick, pump event}; room after each lets outputs settle
    task automatic pulse(input int n, input logic [2:0] k, input logic [7:0] e);
        repeat (n) begin
            {ref_tick_i, fb_tick_i, pd_event_i} <= k;
            phase_err_i <= e;
            wt(1);
            {ref_tick_i, fb_tick_i, pd_event_i} <= 3'b000;
            wt(4);
        end
    endtask : pulse
    function automatic logic [23:0] fw(input logic [1:0] pre, input logic pd2,
        input logic [3:0] tc, input logic md, input logic en, input logic [2:0] mux,
        input logic pd1, input logic hold);
        return {pre, pd2, 3'h5, 3'h2, tc, md, en, 2'h0, mux, pd1, hold, 2'b10};
    endfunction : fw
    function automatic logic [23:0] fbw(input logic g);
        return {2'h0, g, 13'h0003, 6'h00, 2'b01};
    endfunction : fbw
    function automatic logic [23:0] rw(input logic [1:0] ab);
        return {6'h00, ab, 14'h0003, 2'b00};
    endfunction : rw
    initial begin
        wt(12);
        `CHK("powered_down_o", 1'b1, powered_down_o)
        `CHK("cp_tristate_o", 1'b1, cp_tristate_o)
        rst_i <= 1'b0;
        wt(8);
        `CHK("powered_down_o", 1'b0, powered_down_o)
        wr(rw(2'b10));
        `CHK("backlash_width_o", 2'b10, backlash_width_o)
        wr(fbw(1'b0));
        `CHK("modulus_o", 1'b0, modulus_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b1, M_HIGH, 1'b0, 1'b1));
        `CHK("cp_tristate_o", 1'b1, cp_tristate_o)
        `CHK("backlash_width_o", 2'b10, backlash_width_o)
        b_r = rp;
        pulse(6, 3'b110, 8'h00);
        `CHK("ref pulse count", 0, rp - b_r)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b1, M_HIGH, 1'b0, 1'b0));
        `CHK("cp_tristate_o", 1'b0, cp_tristate_o)
        `CHK("prescale_sel_o", 2'b11, prescale_sel_o)
        `CHK("multiplexed_output_o", 1'b1, multiplexed_output_o)
        b_r = rp;
        b_f = fp;
        pulse(9, 3'b110, 8'h00);
        `CHK("ref pulse count", 3, rp - b_r)
        `CHK("fb pulse count", 3, fp - b_f)
        `CHK("cp_current_o", 3'h2, cp_current_o)
        wr(fbw(1'b1));
        `CHK("cp_current_o", 3'h5, cp_current_o)
        pulse(4, 3'b001, 8'h05);
        `CHK("cp_current_o", 3'h5, cp_current_o)
        wr(fbw(1'b0));
        `CHK("cp_current_o", 3'h2, cp_current_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b0, 1'b0));
        wr(fbw(1'b1));
        `CHK("cp_current_o", 3'h2, cp_current_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b1, 1'b1, M_HIGH, 1'b0, 1'b0));
        wr(fbw(1'b1));
        pulse(int'(TMO) - 1, 3'b001, 8'h05);
        `CHK("cp_current_o", 3'h5, cp_current_o)
        pulse(1, 3'b001, 8'h05);
        `CHK("cp_current_o", 3'h2, cp_current_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_DLD, 1'b0, 1'b0));
        pulse(2, 3'b001, 8'h00);
        `CHK("digital_lock_o", 1'b0, digital_lock_o)
        pulse(1, 3'b001, 8'h00);
        `CHK("digital_lock_o", 1'b1, digital_lock_o)
        `CHK("multiplexed_output_o", 1'b1, multiplexed_output_o)
        pulse(1, 3'b001, 8'h01);
        `CHK("digital_lock_o", 1'b1, digital_lock_o)
        pulse(1, 3'b001, 8'h02);
        `CHK("digital_lock_o", 1'b0, digital_lock_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_ALD, 1'b0, 1'b0));
        pd_active_i <= 1'b1;
        wt(3);
        `CHK("multiplexed_output_oe_o", 1'b1, multiplexed_output_oe_o)
        `CHK("multiplexed_output_o", 1'b0, multiplexed_output_o)
        pd_active_i <= 1'b0;
        wt(3);
        `CHK("multiplexed_output_oe_o", 1'b0, multiplexed_output_oe_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_SDATA, 1'b0, 1'b0));
        `CHK("multiplexed_output_o", 1'b1, multiplexed_output_o)
        `CHK("multiplexed_output_oe_o", 1'b1, multiplexed_output_oe_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_LOW, 1'b0, 1'b0));
        `CHK("multiplexed_output_o", 1'b0, multiplexed_output_o)
        pulse(3, 3'b001, 8'h00);
        `CHK("digital_lock_o", 1'b1, digital_lock_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b1, 1'b0));
        `CHK("powered_down_o", 1'b1, powered_down_o)
        `CHK("digital_lock_o", 1'b0, digital_lock_o)
        `CHK("cp_tristate_o", 1'b1, cp_tristate_o)
        wr(rw(2'b01));
        `CHK("backlash_width_o", 2'b01, backlash_width_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b0, 1'b0));
        `CHK("powered_down_o", 1'b0, powered_down_o)
        wr(fw(2'b11, 1'b1, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b1, 1'b0));
        `CHK("powered_down_o", 1'b0, powered_down_o)
        pulse(1, 3'b001, 8'h00);
        `CHK("powered_down_o", 1'b1, powered_down_o)
        wr(fw(2'b11, 1'b0, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b0, 1'b0));
        chip_enable_i <= 1'b0;
        wt(6);
        `CHK("powered_down_o", 1'b1, powered_down_o)
        chip_enable_i <= 1'b1;
        wt(6);
        `CHK("powered_down_o", 1'b0, powered_down_o)
        b_r = tp;
        wr(fw(2'b01, 1'b0, 4'h0, 1'b0, 1'b0, M_HIGH, 1'b0, 1'b0) ^ 24'h000001);
        `CHK("prescale_sel_o", 2'b01, prescale_sel_o)
        `CHK("init hold cycles", 1, tp - b_r)
        b_r = tp;
        wr(fbw(1'b0));
        wr(fbw(1'b0));
        `CHK("first fb hold cycles", 1, tp - b_r)
        complete_run();
    end
    initial begin
        wt(20000);
        fail_count++;
        complete_run();
    end
endmodule : tb_top
bind synth_serial_latch_control latch_control_checker #(.ERR_W(ERR_W), .LOCK_IN(LOCK_IN),
    .LOCK_OUT(LOCK_OUT)) checker_i (.ref_clk_i, .rst_i, .chip_enable_i, .ref_tick_i,
    .fb_tick_i, .pd_event_i, .phase_err_i, .ref_pfd_o, .fb_pfd_o, .powered_down_o,
    .cp_tristate_o, .digital_lock_o);
